// >>> logic/csa_cfg_pkg.sv
// Constants for the current sense amplifier configuration block
package csa_cfg_pkg;
	// Clock rate used to turn times into cycle counts
	localparam int CLK_MHZ = 125;
	// Register location and value after reset
	localparam logic [7:0] CSA_CFG_ADDR = 8'h1d;
	localparam logic [15:0] CSA_CFG_RESET = 16'h0028;
	// Field positions
	localparam int GAIN_LSB = 0;
	localparam int GAIN_SRC_BIT = 3;
	localparam int EN_LSB = 4;
	localparam int BLANK_LSB = 7;
	localparam int DCCAL_BIT = 11;
	localparam int DEGLITCH_LSB = 12;
	localparam int POLICY_LSB = 14;
	// Fault policy codes
	typedef enum logic [1:0] {
		POL_COUNT8 = 2'b00,
		POL_COUNT16 = 2'b01,
		POL_EVERY = 2'b10,
		POL_NONE = 2'b11
	} policy_t;
	// Event counts that raise a fault under the counting policies
	localparam logic [4:0] COUNT_LOW = 5'd8;
	localparam logic [4:0] COUNT_HIGH = 5'd16;
	// Blanking times in ns, indexed by code
	localparam int BLANK_NS [16] = '{0, 50, 100, 200, 300, 400, 500, 600,
		700, 800, 900, 1000, 2000, 4000, 6000, 8000};
	// Deglitch times in us, indexed by code
	localparam int DEGLITCH_US [4] = '{0, 2, 4, 8};
	// Counter width able to hold the longest time (8 us = 1000 cycles)
	localparam int TCNT_W = 11;
	// Least times round up to whole cycles
	function automatic logic [TCNT_W-1:0] blank_cycles(logic [3:0] code);
		blank_cycles = TCNT_W'((BLANK_NS[code] * CLK_MHZ + 999) / 1000);
	endfunction
	function automatic logic [TCNT_W-1:0] deglitch_cycles(logic [1:0] code);
		deglitch_cycles = TCNT_W'(DEGLITCH_US[code] * CLK_MHZ);
	endfunction
endpackage

// >>> logic/current_sense_config.sv
// Current sense amplifier configuration register and overcurrent handling
// Behaviour
// - Gain codes 0..7 give 4,8,12,16,20,24,32,64
// - Gain source bit picks register or pin
// - Enable bits 4..6 drive phases A..C
// - Blanking code selects 0 ns to 8 us
// - Calibration bit forces stages to high impedance
// - Deglitch code selects 0, 2, 4, 8 us
// - Truncation disable low bypasses the deglitch
// - Fault after 8, 16 or every event
// - Code 11 never faults; truncation still acts
module current_sense_config (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port of the device register bank
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Neighbouring state and analog inputs
	input wire logic pulse_truncation_disable,
	input wire logic [2:0] gain_pin_code,
	input wire logic switch_edge,
	input wire logic [2:0] ocp_raw,
	input wire logic fault_clear,
	// Amplifier controls
	output logic [6:0] amp_gain,
	output logic [2:0] amp_enable,
	output logic dc_offset_calibration,
	output logic stage_hiz,
	output logic blanking_active,
	// Overcurrent results
	output logic ocp_event,
	output logic pwm_truncate,
	output logic ocp_fault
);
	import csa_cfg_pkg::*;

	// Only one word lives here; the extension register is outside this
	// block and reaches us as the truncation disable level.
	logic [15:0] cfg_reg; // Configuration word
	logic [TCNT_W-1:0] blank_reg; // Blanking cycles left
	logic [TCNT_W-1:0] dg_reg; // Cycles the overcurrent has persisted
	logic seen_reg; // Event already reported for this overcurrent
	logic [4:0] evt_reg; // Events counted toward a fault
	logic ocp_q; // Qualified comparator level
	logic evt_now; // Filtered event this cycle
	logic [TCNT_W-1:0] dg_target; // Deglitch length in force
	logic [1:0] policy; // Fault policy field
	logic [4:0] evt_next; // Event count after this cycle
	logic fault_hit; // This event raises the fault

	// Gain code to V/V
	// Shared by the register path and the pin path so both decode alike
	function automatic logic [6:0] gain_vv(logic [2:0] code);
		case (code)
			3'd0: gain_vv = 7'd4;
			3'd1: gain_vv = 7'd8;
			3'd2: gain_vv = 7'd12;
			3'd3: gain_vv = 7'd16;
			3'd4: gain_vv = 7'd20;
			3'd5: gain_vv = 7'd24;
			3'd6: gain_vv = 7'd32;
			default: gain_vv = 7'd64;
		endcase
	endfunction

	// Register write; all sixteen bits are read/write
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_reg <= CSA_CFG_RESET;
		end else if (reg_wr && reg_addr == CSA_CFG_ADDR) begin
			cfg_reg <= reg_wdata;
		end
	end

	// Read data is registered; other addresses answer zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_addr == CSA_CFG_ADDR) begin
			reg_rdata <= cfg_reg;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// Amplifier controls follow the register one cycle later
	// The extra stage keeps every control output straight off a flop,
	// at the cost of one cycle of latency after a write.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			amp_gain <= 7'd4;
			amp_enable <= 3'b000;
			dc_offset_calibration <= 1'b0;
			stage_hiz <= 1'b0;
		end else begin
			if (cfg_reg[GAIN_SRC_BIT]) begin
				amp_gain <= gain_vv(gain_pin_code);
			end else begin
				amp_gain <= gain_vv(cfg_reg[GAIN_LSB +: 3]);
			end
			amp_enable <= cfg_reg[EN_LSB +: 3];
			// Stages idle but powered so the offset can be trimmed
			dc_offset_calibration <= cfg_reg[DCCAL_BIT];
			stage_hiz <= cfg_reg[DCCAL_BIT];
		end
	end

	// Blanking window restarts on every switching edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			blank_reg <= '0;
		end else if (switch_edge) begin
			blank_reg <= blank_cycles(cfg_reg[BLANK_LSB +: 4]);
		end else if (blank_reg != '0) begin
			blank_reg <= blank_reg - TCNT_W'(1);
		end
	end

	// Status copy of the window; looks one cycle ahead so it lines up
	// with the cycles in which the comparators are really ignored.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			blanking_active <= 1'b0;
		end else begin
			blanking_active <= switch_edge ?
				(blank_cycles(cfg_reg[BLANK_LSB +: 4]) != '0) :
				(blank_reg > TCNT_W'(1));
		end
	end

	// Comparators count only for enabled phases and outside blanking
	always_comb begin
		ocp_q = |(ocp_raw & cfg_reg[EN_LSB +: 3]) &&
			blank_reg == '0 && !switch_edge;
		if (!pulse_truncation_disable) begin
			dg_target = '0;
		end else begin
			dg_target = deglitch_cycles(cfg_reg[DEGLITCH_LSB +: 2]);
		end
		evt_now = ocp_q && !seen_reg && dg_reg >= dg_target;
	end

	// Deglitch: one event per overcurrent that lasts the filter time
	// The comparator must drop before another event can be reported,
	// so a long overcurrent is counted once, not once per cycle.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dg_reg <= '0;
			seen_reg <= 1'b0;
		end else if (!ocp_q) begin
			dg_reg <= '0;
			seen_reg <= 1'b0;
		end else if (evt_now) begin
			seen_reg <= 1'b1;
		end else if (!seen_reg) begin
			dg_reg <= dg_reg + TCNT_W'(1);
		end
	end

	// Fault decision from the policy field
	// Counting policies compare after the increment, so the event that
	// reaches the threshold is the one that raises the fault.
	always_comb begin
		policy = cfg_reg[POLICY_LSB +: 2];
		evt_next = evt_reg;
		fault_hit = 1'b0;
		if (evt_now) begin
			case (policy)
				POL_COUNT8: begin
					evt_next = evt_reg + 5'd1;
					fault_hit = evt_next >= COUNT_LOW;
				end
				POL_COUNT16: begin
					evt_next = evt_reg + 5'd1;
					fault_hit = evt_next >= COUNT_HIGH;
				end
				POL_EVERY: begin
					fault_hit = 1'b1;
				end
				default: begin
					fault_hit = 1'b0;
				end
			endcase
		end
	end

	// Event counter saturates at the larger threshold
	// An event in the same cycle as a clear keeps the count running, so
	// no overcurrent is lost to a badly timed clear.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			evt_reg <= '0;
		end else if (fault_clear && !evt_now) begin
			evt_reg <= '0;
		end else if (evt_next <= COUNT_HIGH) begin
			evt_reg <= evt_next;
		end
	end

	// Fault is sticky; a new fault wins over a clear in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ocp_fault <= 1'b0;
		end else if (fault_hit) begin
			ocp_fault <= 1'b1;
		end else if (fault_clear) begin
			ocp_fault <= 1'b0;
		end
	end

	// Event and truncation pulses; truncation ignores the fault policy
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ocp_event <= 1'b0;
			pwm_truncate <= 1'b0;
		end else begin
			ocp_event <= evt_now;
			pwm_truncate <= evt_now && !pulse_truncation_disable;
		end
	end
endmodule

// >>> sim/current_sense_config_asserts.sv
// Port checks for the current sense configuration block
module current_sense_config_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [2:0] gain_pin_code,
	input wire logic fault_clear,
	input wire logic [6:0] amp_gain,
	input wire logic [2:0] amp_enable,
	input wire logic stage_hiz,
	input wire logic blanking_active,
	input wire logic ocp_event,
	input wire logic pwm_truncate,
	input wire logic ocp_fault
);
	timeunit 1ns;
	timeprecision 1ps;
	// Gain in V/V for each code
	localparam logic [6:0] GV [8] = '{4, 8, 12, 16, 20, 24, 32, 64};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Controls land two edges after the write is taken
	wire wr_cfg = reg_wr && reg_addr == 8'h1d;
	a_gain_code: assert property (wr_cfg && !reg_wdata[3] |-> ##2
		amp_gain == GV[$past(reg_wdata[2:0], 2)]) else $error("gain");
	a_gain_pin: assert property (wr_cfg && reg_wdata[3] |-> ##2
		amp_gain == GV[$past(gain_pin_code)]) else $error("pin gain");
	a_phase_enable: assert property (wr_cfg |-> ##2
		amp_enable == $past(reg_wdata[6:4], 2)) else $error("enable");
	a_cal_hiz: assert property (wr_cfg |-> ##2
		stage_hiz == $past(reg_wdata[11], 2)) else $error("hiz");
	a_trunc_event: assert property (pwm_truncate |-> ocp_event)
		else $error("truncate");
	a_event_once: assert property (ocp_event |=> !ocp_event)
		else $error("event");
	a_blank_quiet: assert property (blanking_active |=> !ocp_event)
		else $error("blank");
	a_fault_hold: assert property (ocp_fault && !fault_clear |=>
		ocp_fault) else $error("fault");
endmodule

bind current_sense_config current_sense_config_asserts
	current_sense_config_asserts_inst (.*);

// >>> sim/test_current_sense_config.sv
// Self-checking bench for the current sense configuration block
module test_current_sense_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, reg_wr = 0, fault_clear = 0;
	logic switch_edge = 0, pulse_truncation_disable = 0;
	logic [7:0] reg_addr = 8'h1d;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [2:0] gain_pin_code = 3'h5, ocp_raw = 3'h0, amp_enable;
	logic [6:0] amp_gain;
	logic dc_offset_calibration, stage_hiz, blanking_active;
	logic ocp_event, pwm_truncate, ocp_fault;
	int num_errors = 0, compares = 0, cyc = 0, n;
	logic [6:0] gv [8] = '{4, 8, 12, 16, 20, 24, 32, 64};
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
	num_errors++; $display("BAD %0t mismatch", $time); end end
	current_sense_config current_sense_config_inst (.*);
	initial forever #4 ref_clk = ~ref_clk;
	// Cut a hang short
	always @(posedge ref_clk) if (++cyc == 5000) begin
		num_errors++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge ref_clk);
		reg_wr = 0;
		reg_addr = 8'h1d;
		@(negedge ref_clk);
	endtask
	// One short overcurrent on phase B
	task automatic hit();
		ocp_raw = 3'h2;
		@(negedge ref_clk);
		ocp_raw = 0;
		`CHK(pwm_truncate, 1'b1)
		@(negedge ref_clk);
	endtask
	task automatic meas(int e);
		n = 0;
		while (ocp_event !== 1'b1 && n < 1100) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK(n, e)
	endtask
	initial begin
		repeat (3) @(negedge ref_clk);
		rst = 0;
		@(negedge ref_clk);
		`CHK(reg_rdata, 16'h0028)
		`CHK(amp_enable, 3'b010)
		for (int i = 0; i < 8; i++) begin
			wr(8'h1d, 16'(i));
			`CHK(amp_gain, gv[i])
		end
		wr(8'h1d, 16'h0808);
		`CHK(amp_gain, 7'd24)
		`CHK(stage_hiz, 1'b1)
		`CHK(dc_offset_calibration, 1'b1)
		wr(8'h1e, 16'hffff);
		`CHK(reg_rdata, 16'h0808)
		for (int p = 0; p < 4; p++) begin
			wr(8'h1d, 16'(p << 14) | 16'h0070);
			fault_clear = 1;
			@(negedge ref_clk);
			fault_clear = 0;
			for (int k = 1; k < 18; k++) begin
				hit();
				`CHK(ocp_fault, p == 2 || p < 2 && k >= 8 + 8 * p)
			end
		end
		pulse_truncation_disable = 1;
		wr(8'h1d, 16'h1070);
		ocp_raw = 3'h1;
		meas(251);
		`CHK(pwm_truncate, 1'b0)
		ocp_raw = 0;
		pulse_truncation_disable = 0;
		wr(8'h1d, 16'h00f0);
		ocp_raw = 3'h4;
		switch_edge = 1;
		@(negedge ref_clk);
		switch_edge = 0;
		`CHK(blanking_active, 1'b1)
		meas(8);
		ocp_raw = 0;
		wr(8'h1d, 16'h0010);
		ocp_raw = 3'h6;
		meas(1100);
		tally_and_finish();
	end
endmodule
